// ### verilog/fpid_cfg.svh
`ifndef FPID_CFG_SVH
`define FPID_CFG_SVH

`define FPID_OP_PDOWN      8'hb9
`define FPID_OP_RELID      8'hab
`define FPID_OP_MDID       8'h90
`define FPID_OP_MDID2      8'h92
`define FPID_OP_MDID4      8'h94
`define FPID_OP_UID        8'h4b
`define FPID_OP_JEDEC      8'h9f

`define FPID_OPC_BITS      8
`define FPID_IN_RELID      24
`define FPID_IN_MDID       24
`define FPID_IN_MDID2      16
`define FPID_IN_MDID4      8
`define FPID_DUM_MDID4     4
`define FPID_IN_UID        32
`define FPID_ADDR_CLK_1    24
`define FPID_ADDR_CLK_2    12
`define FPID_ADDR_CLK_4    6
`define FPID_MODE_BYTE     8'hf0
`define FPID_LEN_RELID     8
`define FPID_LEN_MDID      16
`define FPID_LEN_UID       64
`define FPID_LEN_JEDEC     24

`define FPID_CLK_NS        50
`define FPID_TDP_NS        3000
`define FPID_TRES1_NS      3000
`define FPID_TRES2_NS      3500
`define FPID_SYNC_LAT      4
`define FPID_GAP_CYC       2
`define FPID_TMR_W         16

// device counts round down and give back the cs synchroniser delay, so it is never late
`define FPID_TDP_DEV_CYC   ((`FPID_TDP_NS / `FPID_CLK_NS) - `FPID_SYNC_LAT)
`define FPID_TRES1_DEV_CYC ((`FPID_TRES1_NS / `FPID_CLK_NS) - `FPID_SYNC_LAT)
`define FPID_TRES2_DEV_CYC ((`FPID_TRES2_NS / `FPID_CLK_NS) - `FPID_SYNC_LAT)
// the host waits the least times, rounded up
`define FPID_TDP_HOST_CYC   ((`FPID_TDP_NS + `FPID_CLK_NS - 1) / `FPID_CLK_NS)
`define FPID_TRES1_HOST_CYC ((`FPID_TRES1_NS + `FPID_CLK_NS - 1) / `FPID_CLK_NS)
`define FPID_TRES2_HOST_CYC ((`FPID_TRES2_NS + `FPID_CLK_NS - 1) / `FPID_CLK_NS)

`endif

// ### verilog/fpid_pkg.sv
`include "fpid_cfg.svh"

package fpid_pkg;

    typedef enum logic [7:0] {
        CMD_PDOWN = 8'h01,
        CMD_RELID = 8'h02,
        CMD_MDID  = 8'h04,
        CMD_MDID2 = 8'h08,
        CMD_MDID4 = 8'h10,
        CMD_UID   = 8'h20,
        CMD_JEDEC = 8'h40,
        CMD_NONE  = 8'h80
    } fpid_cmd_e;

    typedef enum logic [3:0] {
        PWR_RUN   = 4'h1,
        PWR_ENTER = 4'h2,
        PWR_DOWN  = 4'h4,
        PWR_EXIT  = 4'h8
    } fpid_pwr_e;

    typedef enum logic [3:0] {
        HST_IDLE  = 4'h1,
        HST_SHIFT = 4'h2,
        HST_DESEL = 4'h4,
        HST_GAP   = 4'h8
    } fpid_hst_e;

    function automatic logic [7:0] fpid_opcode(input fpid_cmd_e c);
        case (c)
            CMD_PDOWN: return `FPID_OP_PDOWN;
            CMD_RELID: return `FPID_OP_RELID;
            CMD_MDID:  return `FPID_OP_MDID;
            CMD_MDID2: return `FPID_OP_MDID2;
            CMD_MDID4: return `FPID_OP_MDID4;
            CMD_UID:   return `FPID_OP_UID;
            CMD_JEDEC: return `FPID_OP_JEDEC;
            default:   return 8'h00;
        endcase
    endfunction : fpid_opcode

    function automatic fpid_cmd_e fpid_decode(input logic [7:0] op);
        case (op)
            `FPID_OP_PDOWN: return CMD_PDOWN;
            `FPID_OP_RELID: return CMD_RELID;
            `FPID_OP_MDID:  return CMD_MDID;
            `FPID_OP_MDID2: return CMD_MDID2;
            `FPID_OP_MDID4: return CMD_MDID4;
            `FPID_OP_UID:   return CMD_UID;
            `FPID_OP_JEDEC: return CMD_JEDEC;
            default:        return CMD_NONE;
        endcase
    endfunction : fpid_decode

endpackage : fpid_pkg

// ### verilog/fpid_if.sv
`timescale 1ns/1ns

interface fpid_if;
    logic       sclk;
    logic       cs_n;
    logic [3:0] dev_o;
    logic [3:0] dev_oe_n;
    logic [3:0] host_o;
    logic [3:0] host_oe_n;
    logic [3:0] io;

    // undriven lines read as pulled high
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!dev_oe_n[i])
                io[i] = dev_o[i];
            else if (!host_oe_n[i])
                io[i] = host_o[i];
            else
                io[i] = 1'b1;
        end
    end

    modport dev  (input sclk, input cs_n, input io, output dev_o, output dev_oe_n);
    modport host (output sclk, output cs_n, output host_o, output host_oe_n, input io);
endinterface : fpid_if

// ### verilog/fpid_dev.sv
`timescale 1ns/1ns
`include "fpid_cfg.svh"

module fpid_dev
    import fpid_pkg::*;
#(
    parameter logic [7:0]  MFR_ID    = 8'h5a,                 // arbitrary value
    parameter logic [7:0]  DEV_ID    = 8'h3c,                 // arbitrary value
    parameter logic [7:0]  MEM_TYPE  = 8'h40,                 // arbitrary value
    parameter logic [7:0]  CAPACITY  = 8'h18,                 // arbitrary value
    parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
) (
    fpid_if.dev        LINK,
    input  wire logic  CLOCK,
    input  wire logic  RESET_N,
    input  wire logic  BUSY,
    output logic       POWERED_DOWN
);

    // link side, clocked by sclk; cs high resets the frame state, RESET_N the frame summary and the synchronisers
    logic [7:0]  cnt_q;
    logic [6:0]  sh_q;
    fpid_cmd_e   cmd_q;
    logic        swap_q;
    logic [6:0]  pos_q;
    logic [3:0]  dev_o_q;
    logic [3:0]  dev_oe_n_q;
    logic [7:0]  op_q;
    logic        exact8_q;
    logic        long_q;
    logic        pd_m_q;
    logic        pd_s_q;
    logic        busy_m_q;
    logic        busy_s_q;

    // system side
    logic        cs_m_q;
    logic        cs_s_q;
    logic        cs_d_q;
    logic        busy_q;
    fpid_pwr_e   pwr_q;
    logic [`FPID_TMR_W-1:0] tmr_q;
    logic        cs_rise;

    logic [63:0] out_word;
    logic [6:0]  out_len;
    logic [2:0]  out_w;
    logic [63:0] out_cur;
    logic [6:0]  pos_nxt;

    function automatic fpid_cmd_e accept_cmd(input logic [7:0] op, input logic pd, input logic busy);
        fpid_cmd_e c;
        c = fpid_decode(op);
        if (c == CMD_RELID && busy)
            c = CMD_NONE;
        else if (pd && c != CMD_RELID)
            c = CMD_NONE;
        return c;
    endfunction : accept_cmd

    // rising-edge count after which the first output bit is driven
    function automatic logic [7:0] start_of(input fpid_cmd_e c);
        case (c)
            CMD_RELID: return 8'(`FPID_OPC_BITS + `FPID_IN_RELID);
            CMD_MDID:  return 8'(`FPID_OPC_BITS + `FPID_IN_MDID);
            CMD_MDID2: return 8'(`FPID_OPC_BITS + `FPID_IN_MDID2);
            CMD_MDID4: return 8'(`FPID_OPC_BITS + `FPID_IN_MDID4 + `FPID_DUM_MDID4);
            CMD_UID:   return 8'(`FPID_OPC_BITS + `FPID_IN_UID);
            CMD_JEDEC: return 8'(`FPID_OPC_BITS);
            default:   return 8'hff;
        endcase
    endfunction : start_of

    // opcode and address bits are taken on the rising edge
    always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            cnt_q  <= 8'h00;
            sh_q   <= 7'h00;
            cmd_q  <= CMD_NONE;
            swap_q <= 1'b0;
        end else begin
            sh_q <= {sh_q[5:0], LINK.io[0]};
            if (cnt_q != 8'hff)
                cnt_q <= cnt_q + 8'h01;
            if (cnt_q == 8'(`FPID_OPC_BITS - 1))
                cmd_q <= accept_cmd({sh_q, LINK.io[0]}, pd_s_q, busy_s_q);
            // address bit a0 selects which id leads
            if ((cmd_q == CMD_MDID  && cnt_q == 8'(`FPID_OPC_BITS + `FPID_ADDR_CLK_1 - 1)) ||
                (cmd_q == CMD_MDID2 && cnt_q == 8'(`FPID_OPC_BITS + `FPID_ADDR_CLK_2 - 1)) ||
                (cmd_q == CMD_MDID4 && cnt_q == 8'(`FPID_OPC_BITS + `FPID_ADDR_CLK_4 - 1)))
                swap_q <= LINK.io[0];
        end
    end

    // frame summary for the system side; it stays still while cs is high, since sclk then stops
    always_ff @(posedge LINK.sclk or negedge RESET_N) begin
        if (!RESET_N) begin
            op_q     <= 8'h00;
            exact8_q <= 1'b0;
            long_q   <= 1'b0;
        end else begin
            if (cnt_q == 8'(`FPID_OPC_BITS - 1))
                op_q <= {sh_q, LINK.io[0]};
            exact8_q <= (cnt_q == 8'(`FPID_OPC_BITS - 1));
            long_q   <= (cnt_q >= 8'(`FPID_OPC_BITS));
        end
    end

    // levels from the system side; only the first opcode bits can see a stale value
    always_ff @(posedge LINK.sclk or negedge RESET_N) begin
        if (!RESET_N) begin
            pd_m_q   <= 1'b0;
            pd_s_q   <= 1'b0;
            busy_m_q <= 1'b0;
            busy_s_q <= 1'b0;
        end else begin
            pd_m_q   <= POWERED_DOWN;
            pd_s_q   <= pd_m_q;
            busy_m_q <= busy_q;
            busy_s_q <= busy_m_q;
        end
    end

    always_comb begin
        out_word = 64'h0;
        out_len  = 7'(`FPID_LEN_RELID);
        out_w    = 3'd1;
        case (cmd_q)
            CMD_RELID: out_word = {DEV_ID, 56'h0};
            CMD_MDID, CMD_MDID2, CMD_MDID4: begin
                out_word = swap_q ? {DEV_ID, MFR_ID, 48'h0} : {MFR_ID, DEV_ID, 48'h0};
                out_len  = 7'(`FPID_LEN_MDID);
                if (cmd_q == CMD_MDID2)
                    out_w = 3'd2;
                else if (cmd_q == CMD_MDID4)
                    out_w = 3'd4;
            end
            CMD_UID: begin
                out_word = UNIQUE_ID;
                out_len  = 7'(`FPID_LEN_UID);
            end
            CMD_JEDEC: begin
                out_word = {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
                out_len  = 7'(`FPID_LEN_JEDEC);
            end
            default: ;
        endcase
        out_cur = out_word << pos_q;
        pos_nxt = pos_q + 7'(out_w);
        if (pos_nxt >= out_len)
            pos_nxt = 7'h00;
    end

    // ids leave msb first on the falling edge and wrap until cs rises
    always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            pos_q      <= 7'h00;
            dev_o_q    <= 4'h0;
            dev_oe_n_q <= 4'hf;
        end else if (cmd_q != CMD_NONE && cmd_q != CMD_PDOWN && cnt_q >= start_of(cmd_q)) begin
            pos_q <= pos_nxt;
            case (out_w)
                3'd4: begin
                    dev_o_q    <= out_cur[63:60];
                    dev_oe_n_q <= 4'h0;
                end
                3'd2: begin
                    dev_o_q    <= {2'b00, out_cur[63:62]};
                    dev_oe_n_q <= 4'hc;
                end
                default: begin
                    dev_o_q    <= {2'b00, out_cur[63], 1'b0};
                    dev_oe_n_q <= 4'hd;
                end
            endcase
        end
    end

    assign LINK.dev_o    = dev_o_q;
    assign LINK.dev_oe_n = dev_oe_n_q;

    // cs enters through two flops; the edge detector reads only the second and later
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            cs_m_q <= 1'b1;
            cs_s_q <= 1'b1;
            cs_d_q <= 1'b1;
            busy_q <= 1'b0;
        end else begin
            cs_m_q <= LINK.cs_n;
            cs_s_q <= cs_m_q;
            cs_d_q <= cs_s_q;
            busy_q <= BUSY;
        end
    end

    assign cs_rise = cs_s_q && !cs_d_q;

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            pwr_q <= PWR_RUN;
            tmr_q <= '0;
        end else begin
            case (pwr_q)
                PWR_RUN: begin
                    if (cs_rise && op_q == `FPID_OP_PDOWN && exact8_q) begin
                        pwr_q <= PWR_ENTER;
                        tmr_q <= `FPID_TMR_W'(`FPID_TDP_DEV_CYC);
                    end
                end
                PWR_ENTER: begin
                    if (tmr_q == '0)
                        pwr_q <= PWR_DOWN;
                    else
                        tmr_q <= tmr_q - 1'b1;
                end
                PWR_DOWN: begin
                    if (cs_rise && op_q == `FPID_OP_RELID && (exact8_q || long_q) && !busy_q) begin
                        pwr_q <= PWR_EXIT;
                        if (long_q)
                            tmr_q <= `FPID_TMR_W'(`FPID_TRES2_DEV_CYC);
                        else
                            tmr_q <= `FPID_TMR_W'(`FPID_TRES1_DEV_CYC);
                    end
                end
                PWR_EXIT: begin
                    if (tmr_q == '0)
                        pwr_q <= PWR_RUN;
                    else
                        tmr_q <= tmr_q - 1'b1;
                end
                default: pwr_q <= PWR_RUN;
            endcase
        end
    end

    // during entry and release only ab is still recognised
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N)
            POWERED_DOWN <= 1'b0;
        else
            POWERED_DOWN <= (pwr_q != PWR_RUN);
    end

endmodule : fpid_dev

// ### verilog/fpid_host.sv
`timescale 1ns/1ns
`include "fpid_cfg.svh"

module fpid_host
    import fpid_pkg::*;
#(
    parameter int HALF = 4
) (
    fpid_if.host        LINK,
    input  wire logic   CLOCK,
    input  wire logic   RESET_N,
    input  wire logic   REQ_VALID,
    input  fpid_cmd_e   REQ_CMD,
    input  wire logic   REQ_ADDR0,
    input  wire logic [3:0] REQ_BYTES,
    output logic        REQ_READY,
    output logic        RSP_VALID,
    output logic [63:0] RSP_DATA,
    output logic        PD_STATE
);

    fpid_hst_e   st_q;
    fpid_cmd_e   cmd_q;
    logic [7:0]  hc_q;
    logic [7:0]  k_q;
    logic [7:0]  nin_q;
    logic [7:0]  rdst_q;
    logic [7:0]  total_q;
    logic [2:0]  win_q;
    logic [2:0]  wout_q;
    logic [39:0] tx_q;
    logic [63:0] rx_q;
    logic [`FPID_TMR_W-1:0] gap_q;
    logic [3:0]  io_m_q;
    logic [3:0]  io_s_q;
    logic        sclk_q;
    logic        cs_n_q;
    logic [3:0]  ho_q;
    logic [3:0]  hoe_n_q;

    logic [7:0]  nin;
    logic [7:0]  ndum;
    logic [7:0]  nrd;
    logic [2:0]  win;
    logic [2:0]  wout;
    logic [31:0] dat;
    logic [6:0]  rdbits;

    always_comb begin
        win    = 3'd1;
        wout   = 3'd1;
        nin    = 8'h00;
        ndum   = 8'h00;
        dat    = 32'h0;
        rdbits = {REQ_BYTES, 3'b000};
        case (REQ_CMD)
            CMD_RELID: if (REQ_BYTES != 4'h0) nin = 8'(`FPID_IN_RELID);
            CMD_MDID: begin
                nin = 8'(`FPID_IN_MDID);
                dat = {23'h0, REQ_ADDR0, 8'h00};
            end
            CMD_MDID2: begin
                win  = 3'd2;
                wout = 3'd2;
                nin  = 8'(`FPID_IN_MDID2);
                dat  = {23'h0, REQ_ADDR0, `FPID_MODE_BYTE};
            end
            CMD_MDID4: begin
                win  = 3'd4;
                wout = 3'd4;
                nin  = 8'(`FPID_IN_MDID4);
                ndum = 8'(`FPID_DUM_MDID4);
                dat  = {23'h0, REQ_ADDR0, `FPID_MODE_BYTE};
            end
            CMD_UID: nin = 8'(`FPID_IN_UID);
            default: ;
        endcase
        // power-down with bytes adds clocks after the opcode, so the device must discard it
        if (REQ_CMD == CMD_PDOWN && REQ_BYTES == 4'h0)
            nrd = 8'h00;
        else if (wout == 3'd4)
            nrd = 8'(rdbits >> 2);
        else if (wout == 3'd2)
            nrd = 8'(rdbits >> 1);
        else
            nrd = 8'(rdbits);
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            io_m_q <= 4'hf;
            io_s_q <= 4'hf;
        end else begin
            io_m_q <= LINK.io;
            io_s_q <= io_m_q;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q      <= HST_IDLE;
            cmd_q     <= CMD_NONE;
            hc_q      <= 8'h00;
            k_q       <= 8'h00;
            nin_q     <= 8'h00;
            rdst_q    <= 8'h00;
            total_q   <= 8'h00;
            win_q     <= 3'd1;
            wout_q    <= 3'd1;
            tx_q      <= 40'h0;
            rx_q      <= 64'h0;
            gap_q     <= '0;
            sclk_q    <= 1'b0;
            cs_n_q    <= 1'b1;
            ho_q      <= 4'h0;
            hoe_n_q   <= 4'hf;
            REQ_READY <= 1'b1;
            RSP_VALID <= 1'b0;
            RSP_DATA  <= 64'h0;
            PD_STATE  <= 1'b0;
        end else begin
            RSP_VALID <= 1'b0;
            case (st_q)
                HST_IDLE: begin
                    if (REQ_VALID && REQ_READY) begin
                        REQ_READY <= 1'b0;
                        cmd_q     <= REQ_CMD;
                        nin_q     <= nin;
                        rdst_q    <= 8'(`FPID_OPC_BITS) + nin + ndum;
                        total_q   <= 8'(`FPID_OPC_BITS) + nin + ndum + nrd;
                        win_q     <= win;
                        wout_q    <= wout;
                        tx_q      <= {fpid_opcode(REQ_CMD), dat};
                        rx_q      <= 64'h0;
                        k_q       <= 8'h00;
                        cs_n_q    <= 1'b0;
                        ho_q      <= 4'(fpid_opcode(REQ_CMD) >> 7);
                        hoe_n_q   <= 4'he;
                        hc_q      <= 8'(HALF - 1);
                        st_q      <= HST_SHIFT;
                    end
                end
                HST_SHIFT: begin
                    if (hc_q != 8'h00) begin
                        hc_q <= hc_q - 8'h01;
                    end else begin
                        hc_q <= 8'(HALF - 1);
                        if (!sclk_q) begin
                            // device takes the bits now; read data settled since the falling edge
                            sclk_q <= 1'b1;
                            k_q    <= k_q + 8'h01;
                            tx_q   <= tx_q << ((k_q < 8'(`FPID_OPC_BITS)) ? 3'd1 : win_q);
                            if (k_q >= rdst_q) begin
                                if (wout_q == 3'd4)
                                    rx_q <= {rx_q[59:0], io_s_q};
                                else if (wout_q == 3'd2)
                                    rx_q <= {rx_q[61:0], io_s_q[1:0]};
                                else
                                    rx_q <= {rx_q[62:0], io_s_q[1]};
                            end
                        end else begin
                            sclk_q <= 1'b0;
                            if (k_q == total_q) begin
                                st_q    <= HST_DESEL;
                                hoe_n_q <= 4'hf;
                            end else if (k_q < 8'(`FPID_OPC_BITS) || win_q == 3'd1) begin
                                ho_q    <= {3'b000, tx_q[39]};
                                hoe_n_q <= (k_q < 8'(`FPID_OPC_BITS) + nin_q) ? 4'he : 4'hf;
                            end else if (k_q < 8'(`FPID_OPC_BITS) + nin_q) begin
                                ho_q    <= (win_q == 3'd4) ? tx_q[39:36] : {2'b00, tx_q[39:38]};
                                hoe_n_q <= (win_q == 3'd4) ? 4'h0 : 4'hc;
                            end else begin
                                hoe_n_q <= 4'hf;
                            end
                        end
                    end
                end
                HST_DESEL: begin
                    if (hc_q != 8'h00) begin
                        hc_q <= hc_q - 8'h01;
                    end else begin
                        cs_n_q    <= 1'b1;
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= rx_q;
                        st_q      <= HST_GAP;
                        gap_q     <= `FPID_TMR_W'(`FPID_GAP_CYC);
                        if (cmd_q == CMD_PDOWN) begin
                            gap_q    <= `FPID_TMR_W'(`FPID_TDP_HOST_CYC);
                            if (total_q == 8'(`FPID_OPC_BITS))
                                PD_STATE <= 1'b1;
                        end else if (cmd_q == CMD_RELID && PD_STATE) begin
                            PD_STATE <= 1'b0;
                            if (total_q != 8'(`FPID_OPC_BITS))
                                gap_q <= `FPID_TMR_W'(`FPID_TRES2_HOST_CYC);
                            else
                                gap_q <= `FPID_TMR_W'(`FPID_TRES1_HOST_CYC);
                        end
                    end
                end
                HST_GAP: begin
                    if (gap_q != '0) begin
                        gap_q <= gap_q - 1'b1;
                    end else begin
                        st_q      <= HST_IDLE;
                        REQ_READY <= 1'b1;
                    end
                end
                default: st_q <= HST_IDLE;
            endcase
        end
    end

    assign LINK.sclk      = sclk_q;
    assign LINK.cs_n      = cs_n_q;
    assign LINK.host_o    = ho_q;
    assign LINK.host_oe_n = hoe_n_q;

endmodule : fpid_host

// ### tb/fpid_props.sv
`timescale 1ns/1ns
module fpid_props (
    input wire logic       CLOCK,
    input wire logic       RESET_N,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic [3:0] dev_o,
    input wire logic [3:0] dev_oe_n,
    input wire logic [3:0] host_oe_n,
    input wire logic [3:0] io
);
    logic [7:0] n_q;
    logic [7:0] op_q;
    // edge count restarts with every frame, saturates so long reads never wrap
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n)
            n_q <= 8'h00;
        else if (n_q != 8'hff)
            n_q <= n_q + 8'h01;
    end
    always_ff @(posedge sclk) begin
        if (n_q < 8'h08)
            op_q <= {op_q[6:0], io[0]};
    end
    sequence s_cmd(logic [7:0] o);
        n_q >= 8'h08 && op_q == o;
    endsequence
    a_cs_oe_off: assert property (@(posedge CLOCK) disable iff (!RESET_N) cs_n |-> dev_oe_n == 4'hf)
        else $error("drive while idle");
    a_idle_sclk: assert property (@(posedge CLOCK) disable iff (!RESET_N) cs_n |-> !sclk)
        else $error("clock while idle");
    a_no_clash: assert property (@(posedge CLOCK) disable iff (!RESET_N) &(dev_oe_n | host_oe_n))
        else $error("both drive");
    a_fall_out: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !cs_n && $changed(dev_o) |-> !sclk) else $error("out change high");
    a_op_quiet: assert property (@(posedge sclk) disable iff (!RESET_N || cs_n)
        n_q < 8'h08 |-> dev_oe_n == 4'hf) else $error("out in opcode");
    a_pd_quiet: assert property (@(posedge sclk) disable iff (!RESET_N || cs_n)
        s_cmd(8'hb9) |-> dev_oe_n == 4'hf) else $error("out on b9");
    a_ab_dummy: assert property (@(posedge sclk) disable iff (!RESET_N || cs_n)
        s_cmd(8'hab) ##0 n_q < 8'h20 |-> dev_oe_n == 4'hf) else $error("ab early");
    a_uid_dummy: assert property (@(posedge sclk) disable iff (!RESET_N || cs_n)
        s_cmd(8'h4b) ##0 n_q < 8'h28 |-> dev_oe_n == 4'hf) else $error("uid early");
endmodule : fpid_props

// ### tb/test_flash_powerdown_and_id_commands.sv
`timescale 1ns/1ns
module test_flash_powerdown_and_id_commands
    import fpid_pkg::*;
;
    logic        clock = 1'h0, reset_n = 1'h0, busy = 1'h0, vld = 1'h0, a0 = 1'h0;
    logic        rdy, rv, pds, pdn;
    fpid_cmd_e   cmd = CMD_NONE;
    logic [3:0]  nb = 4'h0;
    logic [63:0] data;
    int          n_errors = 0, compares = 0;
    fpid_if lnk ();
    fpid_dev u_fpid_dev (.LINK(lnk), .CLOCK(clock), .RESET_N(reset_n), .BUSY(busy), .POWERED_DOWN(pdn));
    fpid_host u_fpid_host (.LINK(lnk), .CLOCK(clock), .RESET_N(reset_n), .REQ_VALID(vld), .REQ_CMD(cmd),
        .REQ_ADDR0(a0), .REQ_BYTES(nb), .REQ_READY(rdy), .RSP_VALID(rv), .RSP_DATA(data), .PD_STATE(pds));
    fpid_props u_fpid_props (.CLOCK(clock), .RESET_N(reset_n), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
        .dev_o(lnk.dev_o), .dev_oe_n(lnk.dev_oe_n), .host_oe_n(lnk.host_oe_n), .io(lnk.io));
    initial forever #25 clock = ~clock;
    task automatic check(input logic [63:0] s, input logic [63:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    // bounded wait, sampled just after the edge so flop updates have landed
    task automatic wait_hi(input bit on_rsp);
        for (int i = 0; i < 3000 && (on_rsp ? rv : rdy) !== 1'h1; i++) begin
            @(posedge clock);
            #1;
        end
        if ((on_rsp ? rv : rdy) !== 1'h1) begin
            n_errors++;
            tally_and_finish();
        end
    endtask : wait_hi
    task automatic req(input fpid_cmd_e c, input logic a, input logic [3:0] n, input logic [63:0] e);
        wait_hi(1'b0);
        @(posedge clock);
        vld <= 1'h1;
        cmd <= c;
        a0 <= a;
        nb <= n;
        @(posedge clock);
        vld <= 1'h0;
        wait_hi(1'b1);
        if (n != 4'h0)
            check(data, e);
    endtask : req
    // power state is looked at once the release or entry time has run out
    task automatic pd_is(input logic e);
        wait_hi(1'b0);
        repeat (8) @(posedge clock);
        #1;
        check(pdn, e);
    endtask : pd_is
    initial begin
        repeat (12) @(posedge clock);
        reset_n <= 1'h1;
        @(posedge clock);
        #1;
        check({pdn, pds}, 64'h0);
        req(CMD_JEDEC, 1'h0, 4'h3, 64'h5a4018);
        req(CMD_RELID, 1'h0, 4'h2, 64'h3c3c);
        req(CMD_MDID, 1'h0, 4'h4, 64'h5a3c5a3c);
        req(CMD_MDID, 1'h1, 4'h3, 64'h3c5a3c);
        req(CMD_MDID2, 1'h0, 4'h2, 64'h5a3c);
        req(CMD_MDID4, 1'h1, 4'h4, 64'h3c5a3c5a);
        req(CMD_UID, 1'h0, 4'h8, 64'h0123456789abcdef);
        req(CMD_PDOWN, 1'h0, 4'h1, 64'hff);
        pd_is(1'h0);
        req(CMD_PDOWN, 1'h0, 4'h0, 64'h0);
        pd_is(1'h1);
        req(CMD_JEDEC, 1'h0, 4'h3, 64'hffffff);
        req(CMD_RELID, 1'h0, 4'h0, 64'h0);
        pd_is(1'h0);
        req(CMD_PDOWN, 1'h0, 4'h0, 64'h0);
        req(CMD_RELID, 1'h0, 4'h1, 64'h3c);
        pd_is(1'h0);
        @(posedge clock);
        busy <= 1'h1;
        req(CMD_RELID, 1'h0, 4'h1, 64'hff);
        @(posedge clock);
        busy <= 1'h0;
        req(CMD_JEDEC, 1'h0, 4'h3, 64'h5a4018);
        tally_and_finish();
    end
endmodule : test_flash_powerdown_and_id_commands
